// ==== logic/crc_detect_dev.sv ====
/*
  error-detection end: storage and signature registers, error flag on the
  divided detection tick, and the 32-bit load/shift readout cell.
  assumes rd_clk, shift_nld and ld_src arrive synchronous to clk and that
  computed CRC results are offered on a valid/ready stream.
*/
// Summary of operation
// R1: load and shift only on readout rising edge
// R2: shift_nld high shifts toward regout each edge
// R3: reader holds shift_nld low two edges to load
// R4: load with ld_src low takes stored crc
// R5: load with ld_src high takes signature
// R6: ld_src ignored while shifting
// R7: error flag timed by detection clock only
// R8: flag high when computed crc differs
// R9: flag reaches core only via enabled pin
// R10: one bit per readout cycle, 31 more
// R11: detection clock is oscillator over divisor; here the 50 MHz clk is divided instead
// R12: reader trusts flag over read signature
// R13: divisor is 2^n, n from 0 to 8
// R14: signature zero when no error
// R15: storage takes crc at configuration end
// R16: flag holds through next calculation
// R17: msb first after load, then descending
`timescale 1ns/1ps
module crc_detect_dev
#(
  parameter int unsigned W     = crc_readout_pkg::CRC_W,
  parameter int unsigned DEPTH = crc_readout_pkg::BUF_DEPTH
)
(
  input  wire logic                                   clk,
  input  wire logic                                   srst,
  crc_readout_if.dev                                  link,
  input  wire logic [crc_readout_pkg::DIV_EXP_W-1:0]  div_exp,
  input  wire logic                                   cfg_done,
  input  wire logic [W-1:0]                           cfg_crc,
  input  wire logic                                   calc_valid,
  input  wire logic [W-1:0]                           calc_crc,
  output logic                                        calc_ready,
  output logic                                        det_tick,
  output logic [W-1:0]                                signature
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [W-1:0]                              storage_q;
  logic [W-1:0]                              sig_q;
  logic [W-1:0]                              shreg_q;
  logic                                      rd_clk_prev_q;
  logic                                      rd_rise;
  logic                                      err_q;
  logic [crc_readout_pkg::DIV_CNT_W-1:0]     div_cnt_q;
  logic [crc_readout_pkg::DIV_CNT_W-1:0]     div_top;
  logic [crc_readout_pkg::DIV_EXP_W-1:0]     exp_eff;
  logic                                      tick_q;
  logic [W-1:0]                              buf_mem [DEPTH];
  logic [PW-1:0]                             wr_ptr_q;
  logic [PW-1:0]                             rd_ptr_q;
  logic [PW:0]                               count_q;
  logic                                      push;
  logic                                      pop;
  logic                                      out_valid;
  logic [W-1:0]                              sig_next;

  // clamp divisor exponent; beyond the top value the slowest rate is used
  always_comb
  begin
    if (div_exp > crc_readout_pkg::DIV_EXP_MAX)
    begin
      exp_eff = crc_readout_pkg::DIV_EXP_MAX;  // see R13
    end
    else
    begin
      exp_eff = div_exp;
    end
  end

  // divider top = 2^n - 1; 9-bit shift cut back to counter width
  always_comb
  begin
    div_top = 8'(({1'b0, 8'hFF} >> (4'h8 - exp_eff)));  // see R11
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end
    else if (div_cnt_q >= div_top)
    begin
      div_cnt_q <= '0;
      tick_q    <= 1'b1;  // see R11
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 8'h01;
      tick_q    <= 1'b0;
    end
  end

  assign det_tick = tick_q;

  // storage takes the reference crc once configuration finishes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      storage_q <= crc_readout_pkg::CRC_RST;
    end
    else if (cfg_done)
    begin
      storage_q <= cfg_crc;  // see R15
    end
  end

  // two-entry buffer for computed results; stalls the engine when full
  assign push       = calc_valid && calc_ready;
  assign out_valid  = (count_q != '0);
  assign pop        = out_valid && tick_q;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      buf_mem[wr_ptr_q] <= calc_crc;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      count_q    <= '0;
      calc_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= PW'((int'(wr_ptr_q) + 1) % DEPTH);
      end
      if (pop)
      begin
        rd_ptr_q <= PW'((int'(rd_ptr_q) + 1) % DEPTH);
      end
      if (push && !pop)
      begin
        count_q    <= count_q + 1'b1;
        calc_ready <= (int'(count_q) + 1 < DEPTH);
      end
      else if (pop && !push)
      begin
        count_q    <= count_q - 1'b1;
        calc_ready <= 1'b1;
      end
    end
  end

  // difference against reference: zero means clean contents
  assign sig_next = buf_mem[rd_ptr_q] ^ storage_q;  // see R14

  // result applied only on the detection tick, never on readout edges
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sig_q <= crc_readout_pkg::SIG_CLEAR;
      err_q <= 1'b0;
    end
    else if (pop)
    begin
      sig_q <= sig_next;  // see R14
      // flag only changes at the end of a calculation, so it holds through
      // the next one and drops only if that one comes out clean
      err_q <= (sig_next != crc_readout_pkg::SIG_CLEAR);  // see R7 see R8 see R16
    end
  end

  assign signature = sig_q;

  // flag pin driven from the first clk after reset releases so core logic can read it back
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      link.err_oe <= 1'b0;
    end
    else
    begin
      link.err_oe <= 1'b1;  // see R9
    end
  end

  assign link.err_o = err_q;

  // readout clock edge found by comparing with its previous level
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_clk_prev_q <= 1'b0;
    end
    else
    begin
      rd_clk_prev_q <= link.rd_clk;
    end
  end

  assign rd_rise = link.rd_clk && !rd_clk_prev_q;  // see R1

  // readout cell; a load repeats on every low edge, so holding shift_nld low
  // for two edges is harmless and the second load wins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shreg_q <= '0;
    end
    else if (rd_rise)
    begin
      if (link.shift_nld)
      begin
        shreg_q <= {shreg_q[W-2:0], 1'b0};  // see R2 see R6 see R10 see R17
      end
      else if (link.ld_src)
      begin
        shreg_q <= sig_q;  // see R5
      end
      else
      begin
        shreg_q <= storage_q;  // see R3 see R4
      end
    end
  end

  assign link.regout = shreg_q[W-1];  // see R10 see R17

endmodule

// ==== logic/crc_reader_host.sv ====
/*
  core-logic reader: APB slave with control, status and data words; makes
  the readout clock by division, loads the cell and shifts out 32 bits.
  assumes the device samples rd_clk on the same clk and answers within one
  clk of a rising readout edge.
*/
`timescale 1ns/1ps
module crc_reader_host
#(
  parameter int unsigned W    = crc_readout_pkg::CRC_W,
  parameter int unsigned HALF = crc_readout_pkg::RD_HALF
)
(
  input  wire logic         clk,
  input  wire logic         srst,
  crc_readout_if.host       link,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);

  crc_readout_pkg::rd_state_e state_q;

  logic [crc_readout_pkg::HALF_W-1:0]  half_q;
  logic                                phase_tick;
  logic [crc_readout_pkg::CNT_W-1:0]   cnt_q;
  logic [W-1:0]                        word_q;
  logic                                word_valid_q;
  logic                                src_q;
  logic                                go;
  logic                                setup;
  logic                                wr_ok;
  logic                                falling;
  logic                                rising;

  assign setup   = psel && !penable;
  assign wr_ok   = psel && penable && pready && pwrite;
  assign go      = wr_ok && (paddr == crc_readout_pkg::CTRL_OFS)
                   && pwdata[crc_readout_pkg::CTRL_GO_BIT];
  assign phase_tick = (state_q != crc_readout_pkg::RD_IDLE)
                      && (half_q == crc_readout_pkg::HALF_W'(HALF - 1));
  assign rising  = phase_tick && !link.rd_clk;
  assign falling = phase_tick && link.rd_clk;

  // no wait state: answer prepared in setup, given in first access cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (setup)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (paddr == crc_readout_pkg::CTRL_OFS)
      begin
        prdata[crc_readout_pkg::CTRL_SRC_BIT] <= src_q;
      end
      else if (paddr == crc_readout_pkg::STATUS_OFS)
      begin
        prdata[crc_readout_pkg::STAT_BUSY_BIT]  <=
          (state_q != crc_readout_pkg::RD_IDLE);
        prdata[crc_readout_pkg::STAT_ERR_BIT]   <= link.err;  // see R9 see R12
        prdata[crc_readout_pkg::STAT_VALID_BIT] <= word_valid_q;
      end
      else if (paddr == crc_readout_pkg::DATA_OFS)
      begin
        prdata <= word_q;
      end
      else
      begin
        pslverr <= 1'b1;
      end
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // source select, held steady through a whole readout
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      src_q <= 1'b0;
    end
    else if (wr_ok && paddr == crc_readout_pkg::CTRL_OFS
             && state_q == crc_readout_pkg::RD_IDLE)
    begin
      src_q <= pwdata[crc_readout_pkg::CTRL_SRC_BIT];
    end
  end

  assign link.ld_src = src_q;

  // readout clock divider; runs only during a readout
  always_ff @(posedge clk)
  begin
    if (srst || state_q == crc_readout_pkg::RD_IDLE)
    begin
      half_q      <= '0;
      link.rd_clk <= 1'b0;
    end
    else if (phase_tick)
    begin
      half_q      <= '0;
      link.rd_clk <= !link.rd_clk;
    end
    else
    begin
      half_q <= half_q + 1'b1;
    end
  end

  // load for two edges, then capture 32 bits with 31 shift edges between
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q        <= crc_readout_pkg::RD_IDLE;
      link.shift_nld <= 1'b1;
      cnt_q          <= '0;
      word_q         <= '0;
      word_valid_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        crc_readout_pkg::RD_IDLE:
        begin
          if (go)
          begin
            state_q        <= crc_readout_pkg::RD_LOAD;
            link.shift_nld <= 1'b0;  // see R3
            cnt_q          <= '0;
            word_valid_q   <= 1'b0;
          end
        end
        crc_readout_pkg::RD_LOAD:
        begin
          if (rising)
          begin
            cnt_q <= cnt_q + 1'b1;
          end
          else if (falling
                   && cnt_q == crc_readout_pkg::CNT_W'(
                      crc_readout_pkg::LOAD_EDGES))
          begin
            word_q         <= {word_q[W-2:0], link.regout};  // see R17
            cnt_q          <= crc_readout_pkg::CNT_W'(1);
            link.shift_nld <= 1'b1;
            state_q        <= crc_readout_pkg::RD_SHIFT;
          end
        end
        crc_readout_pkg::RD_SHIFT:
        begin
          if (falling)
          begin
            word_q <= {word_q[W-2:0], link.regout};  // see R10
            if (cnt_q == crc_readout_pkg::CNT_W'(W - 1))
            begin
              state_q      <= crc_readout_pkg::RD_IDLE;
              word_valid_q <= 1'b1;
            end
            else
            begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        default:
        begin
          state_q <= crc_readout_pkg::RD_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== logic/crc_readout_if.sv ====
/*
  link between the error-detection block and the core logic reading it.
  assumes the reader makes the readout clock from the shared system clock;
  the error flag pin is resolved here from its drive enable.
*/
`timescale 1ns/1ps
interface crc_readout_if;

  logic rd_clk;
  logic shift_nld;
  logic ld_src;
  logic regout;
  logic err_o;
  logic err_oe;
  logic err;

  // flag pin: undriven reads low
  assign err = err_oe ? err_o : 1'b0;

  modport dev
  (
    input  rd_clk,
    input  shift_nld,
    input  ld_src,
    output regout,
    output err_o,
    output err_oe
  );

  modport host
  (
    output rd_clk,
    output shift_nld,
    output ld_src,
    input  regout,
    input  err
  );

endinterface

// ==== logic/crc_readout_pkg.sv ====
/*
  shared constants for the error-detection readout pair: word width,
  divider limits, readout clock pacing and the controller register map.
  assumes a single 50 MHz system clock shared by both ends.
*/
package crc_readout_pkg;

  localparam int unsigned CRC_W        = 32;
  localparam int unsigned CNT_W        = 5;
  localparam int unsigned DIV_EXP_W    = 4;
  localparam logic [3:0]  DIV_EXP_MAX  = 4'h8;
  localparam int unsigned DIV_CNT_W    = 8;
  localparam int unsigned OSC_MHZ      = 80;
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned LOAD_EDGES   = 2;
  localparam int unsigned RD_HALF      = 2;
  localparam int unsigned HALF_W       = 8;
  localparam int unsigned BUF_DEPTH    = 2;

  localparam logic [CRC_W-1:0] SIG_CLEAR = 32'h0000_0000;
  localparam logic [CRC_W-1:0] CRC_RST   = 32'h0000_0000;

  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] DATA_OFS   = 12'h008;

  localparam int unsigned CTRL_GO_BIT     = 0;
  localparam int unsigned CTRL_SRC_BIT    = 1;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_ERR_BIT    = 1;
  localparam int unsigned STAT_VALID_BIT  = 2;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_LOAD,
    RD_SHIFT
  } rd_state_e;

endpackage

// ==== verification/crc_readout_checker.sv ====
/*
  assertions on the readout link joining the two ends.
  assumes one clock, sync active-high reset, readout half period of 2.
*/
`timescale 1ns/1ps
module crc_readout_checker
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rd_clk,
  input wire logic shift_nld,
  input wire logic ld_src,
  input wire logic regout,
  input wire logic err_o,
  input wire logic err_oe,
  input wire logic err,
  input wire logic det_tick
);
  logic       rd_prev_q;
  logic [1:0] ld_rise_q;
  logic [5:0] sh_rise_q;
  logic       rise;

  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);

  assign rise = rd_clk & ~rd_prev_q;

  always_ff @(posedge clk)
  begin
    rd_prev_q <= rd_clk;
  end

  // saturates: only the two-rise minimum matters
  always_ff @(posedge clk)
  begin
    if (srst || shift_nld)
      ld_rise_q <= 2'h0;
    else if (rise && ld_rise_q != 2'h3)
      ld_rise_q <= ld_rise_q + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst || !shift_nld)
      sh_rise_q <= 6'h00;
    else if (rise && sh_rise_q != 6'h3F)
      sh_rise_q <= sh_rise_q + 6'h01;
  end

  a_regout_on_rise: assert property (
    !$stable(regout) |-> $past(rd_clk) || $past(rd_clk, 2))
    else $error("regout moved without a readout rise");
  a_two_load_rises: assert property (
    $rose(shift_nld) |-> ld_rise_q >= 2'h2)
    else $error("load held for fewer than two rises");
  a_pin_enabled: assert property (
    !$past(srst) |-> err_oe)
    else $error("flag pin not enabled");
  a_pin_follows: assert property (
    err_oe |-> err == err_o)
    else $error("flag pin differs from flag");
  a_flag_on_tick: assert property (
    !$stable(err_o) |-> $past(det_tick) || $past(det_tick, 2))
    else $error("flag moved off the detection tick");
  a_rdclk_half: assert property (
    $rose(rd_clk) |=> rd_clk ##1 !rd_clk)
    else $error("readout clock half period wrong");
  a_src_steady: assert property (
    !shift_nld && !$past(shift_nld) |-> $stable(ld_src))
    else $error("load source moved during load");
  a_shift_count: assert property (
    $fell(shift_nld) |-> sh_rise_q == 6'h00 || sh_rise_q >= 6'h1F)
    else $error("word shifted with too few rises");
endmodule

// ==== verification/tb_crc_error_detect_readout.sv ====
/*
  testbench: both ends joined by the link; apb reads of stored crc and
  signature, error flag, divider spacing, stream stall, mid-run reset.
  assumes host readout half period of 2 clocks.
*/
`timescale 1ns/1ps
module tb_crc_error_detect_readout;
  typedef struct packed
  {
    logic [31:0] exp;
    logic [31:0] msk;
    logic        err;
  } note_s;

  logic        clk;
  logic        srst;
  logic [3:0]  div_exp;
  logic        cfg_done;
  logic [31:0] cfg_crc;
  logic        calc_valid;
  logic [31:0] calc_crc;
  logic        calc_ready;
  logic        det_tick;
  logic [31:0] signature;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] ref_crc;
  logic [31:0] bad;
  logic [31:0] q;
  note_s       notes[$];
  int          err_total;
  int          n_compared;
  int          seed;
  int          c;

  crc_readout_if link();
  crc_detect_dev u_crc_detect_dev(.clk(clk), .srst(srst), .link(link),
    .div_exp(div_exp), .cfg_done(cfg_done), .cfg_crc(cfg_crc),
    .calc_valid(calc_valid), .calc_crc(calc_crc),
    .calc_ready(calc_ready), .det_tick(det_tick), .signature(signature));
  crc_reader_host #(.HALF(2)) u_crc_reader_host(.clk(clk), .srst(srst),
    .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  crc_readout_checker u_chk(.clk(clk), .srst(srst), .rd_clk(link.rd_clk),
    .shift_nld(link.shift_nld), .ld_src(link.ld_src),
    .regout(link.regout), .err_o(link.err_o), .err_oe(link.err_oe),
    .err(link.err), .det_tick(det_tick));

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // unmapped offsets used here all lie above the data word
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m, output logic [31:0] r);
    @(posedge clk);
    notes.push_back('{e, m, a > crc_readout_pkg::DATA_OFS});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung access
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic read_word(input logic src, input logic [31:0] e,
                           input logic fl);
    logic [31:0] r;
    int n;
    apb(1'b1, crc_readout_pkg::CTRL_OFS, {30'h0, src, 1'b1}, 32'h0,
        32'h0, r);
    n = 0;
    do
    begin
      apb(1'b0, crc_readout_pkg::STATUS_OFS, 32'h0, 32'h0, 32'h0, r);
      n++;
    end
    while (r[0] !== 1'b0 && n < 100);
    apb(1'b0, crc_readout_pkg::STATUS_OFS, 32'h0, {29'h0, 1'b1, fl, 1'b0},
        32'h7, r);
    apb(1'b0, crc_readout_pkg::DATA_OFS, 32'h0, e, 32'hFFFF_FFFF, r);
  endtask

  task automatic push(input logic [31:0] v);
    @(posedge clk);
    calc_valid <= 1'b1;
    calc_crc   <= v;
    // word taken at the edge where ready is seen high
    do
    begin
      @(posedge clk);
    end
    while (calc_ready !== 1'b1);
    calc_valid <= 1'b0;
  endtask

  task automatic wait_tick(output int k);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (det_tick !== 1'b1 && k < 600);
  endtask

  task automatic settle();
    int k;
    wait_tick(k);
    repeat (3) @(negedge clk);
  endtask

  always @(posedge clk)
  begin
    note_s nt;
    if (psel && penable && pready === 1'b1)
    begin
      nt = notes.pop_front();
      chk("prdata", nt.exp, prdata & nt.msk);
      chk("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    seed = 32'hB1B54954;
    srst = 1'b1;
    div_exp = 4'h0;
    cfg_done = 1'b0;
    cfg_crc = 32'h0;
    calc_valid = 1'b0;
    calc_crc = 32'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ref_crc = $random(seed);
    bad = ref_crc ^ ($random(seed) | 32'h1);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    read_word(1'b1, 32'h0, 1'b0);
    @(posedge clk);
    cfg_done <= 1'b1;
    cfg_crc  <= ref_crc;
    @(posedge clk);
    cfg_done <= 1'b0;
    read_word(1'b0, ref_crc, 1'b0);
    $display("test load sources done");
    push(bad);
    settle();
    chk("signature", ref_crc ^ bad, signature);
    chk("err pin", 32'h1, {31'h0, link.err});
    read_word(1'b1, ref_crc ^ bad, 1'b1);
    read_word(1'b0, ref_crc, 1'b1);
    push(ref_crc);
    settle();
    chk("err pin", 32'h0, {31'h0, link.err});
    chk("signature", 32'h0, signature);
    $display("test error flag done");
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      div_exp <= (i == 9) ? 4'hF : 4'(i);
      wait_tick(c);
      wait_tick(c);
      wait_tick(c);
      chk("tick spacing", 32'h1 << ((i > 8) ? 8 : i), 32'(c));
    end
    $display("test divider done");
    // two words fill the buffer; the third stalls until a pop
    wait_tick(c);
    push(bad);
    push(bad ^ 32'h2);
    @(negedge clk);
    chk("calc_ready", 32'h0, {31'h0, calc_ready});
    push(ref_crc);
    repeat (3) @(negedge clk);
    chk("err pin", 32'h1, {31'h0, link.err});
    settle();
    chk("err pin", 32'h1, {31'h0, link.err});
    settle();
    chk("err pin", 32'h0, {31'h0, link.err});
    $display("test stream stall done");
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, 32'h0, 32'h0, q);
    apb(1'b0, 12'h00C, 32'h0, 32'h0, 32'h0, q);
    read_word(1'b0, ref_crc, 1'b0);
    $display("test unmapped done");
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    read_word(1'b0, 32'h0, 1'b0);
    $display("test reset done");
    end_of_test();
  end
endmodule
